// ===== dps_pkg.sv
package dps_pkg;

  // object indices of the drive dictionary
  localparam logic [15:0] DPS_IDX_COMMAND = 16'h6040;
  localparam logic [15:0] DPS_IDX_STATE = 16'h6041;
  localparam logic [15:0] DPS_IDX_MODE_REQ = 16'h6060;
  localparam logic [15:0] DPS_IDX_MODE_ACT = 16'h6061;

  // command word bit positions
  localparam int DPS_CW_SWITCH_ON = 0;
  localparam int DPS_CW_VOLTAGE = 1;
  localparam int DPS_CW_QSTOP_N = 2;
  localparam int DPS_CW_ENABLE = 3;
  localparam int DPS_CW_FAULT_RST = 7;

  // values after reset
  localparam logic [15:0] DPS_COMMAND_RST = 16'h0000;
  localparam logic [7:0] DPS_MODE_RST = 8'h00;

  typedef enum logic [2:0] {
    DPS_NOT_READY = 3'b000,
    DPS_ON_DISABLED = 3'b001,
    DPS_READY = 3'b010,
    DPS_SWITCHED_ON = 3'b011,
    DPS_OP_ENABLED = 3'b100,
    DPS_QSTOP = 3'b101,
    DPS_FAULT_REACT = 3'b110,
    DPS_FAULT = 3'b111
  } dps_state_t;

  // one dictionary access from the fieldbus side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } dps_obj_req_t;

  // answer to a dictionary access
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } dps_obj_rsp_t;

endpackage

// ===== dps_power_fsm.sv
`timescale 1ns/1ps

// Behaviour
// RL1 - state bits 6,3..0: off/disabled/ready encodings
// RL2 - switched on, enabled, quickstop, fault encodings
// RL3 - shutdown command enters ready to switch on
// RL4 - switch on / disable operation reach switched on
// RL5 - disable voltage returns to switch on disabled
// RL6 - quick stop enters quick stop active
// RL7 - enable operation from switched on
// RL8 - fault reset, quickstop return on rising edge
// RL9 - self-test passed enters switch on disabled
// RL10 - requests via command word, state in status
// RL11 - mode requested anytime, active mode shown
// RL12 - fault reset uses command bit 7 edge
// RL13 - unmatched command leaves state unchanged
module dps_power_fsm
  import dps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // dictionary access
  input wire dps_obj_req_t obj_req,
  output dps_obj_rsp_t obj_rsp,
  // drive core events
  input wire logic selftest_ok,
  input wire logic fault_event,
  input wire logic fault_reaction_done,
  // drive state view
  output dps_state_t drive_state,
  output logic [15:0] drive_state_word,
  output logic [7:0] active_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // status word encoding, applied to the next state when the status word register loads
  function automatic logic [15:0] state_code(input dps_state_t s);
    case (s)
      DPS_NOT_READY: state_code = 16'h0000; // [RL1]
      DPS_ON_DISABLED: state_code = 16'h0040; // [RL1]
      DPS_READY: state_code = 16'h0021; // [RL1]
      DPS_SWITCHED_ON: state_code = 16'h0023; // [RL2]
      DPS_OP_ENABLED: state_code = 16'h0027; // [RL2]
      DPS_QSTOP: state_code = 16'h0007; // [RL2]
      DPS_FAULT_REACT: state_code = 16'h000f; // [RL2]
      DPS_FAULT: state_code = 16'h0008; // [RL2]
      default: state_code = 16'h0000;
    endcase
  endfunction

  logic [15:0] command_word;
  logic [15:0] prev_command;
  logic [7:0] mode_req;
  dps_state_t next_state;
  logic [15:0] next_command;
  logic [7:0] next_mode_req;
  dps_obj_rsp_t next_rsp;
  logic cmd_shutdown, cmd_switch_on, cmd_dis_voltage, cmd_qstop, cmd_enable;
  logic rise_fault_rst, rise_qstop_n;

  ////////////////////////////////////////////////////////////////////////////
  // command decode; bit 7 low is required for every level command
  always_comb
  begin
    cmd_shutdown = !command_word[7] && command_word[2:0] == 3'b110; // [RL3]
    cmd_switch_on = !command_word[7] && command_word[3:0] == 4'b0111; // [RL4]
    cmd_dis_voltage = !command_word[7] && !command_word[DPS_CW_VOLTAGE]; // [RL5]
    cmd_qstop = !command_word[7] && command_word[2:1] == 2'b01; // [RL6]
    cmd_enable = !command_word[7] && command_word[3:0] == 4'b1111; // [RL7]
    // edges are taken against the word seen one cycle earlier, so a held level fires once
    rise_fault_rst = command_word[DPS_CW_FAULT_RST] && !prev_command[DPS_CW_FAULT_RST]; // [RL8] [RL12]
    rise_qstop_n = command_word[DPS_CW_QSTOP_N] && !prev_command[DPS_CW_QSTOP_N]; // [RL8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state transitions; a fault from the core overrides any command outside the not ready and fault states
  always_comb
  begin
    next_state = drive_state; // [RL13]
    case (drive_state)
      DPS_NOT_READY:
        if (selftest_ok) next_state = DPS_ON_DISABLED; // [RL9]
      DPS_ON_DISABLED:
        if (cmd_shutdown) next_state = DPS_READY; // [RL3]
      DPS_READY:
        if (cmd_dis_voltage) next_state = DPS_ON_DISABLED; // [RL5]
        else if (cmd_switch_on) next_state = DPS_SWITCHED_ON; // [RL4]
      DPS_SWITCHED_ON:
        if (cmd_dis_voltage) next_state = DPS_ON_DISABLED; // [RL5]
        else if (cmd_shutdown) next_state = DPS_READY; // [RL3]
        else if (cmd_enable) next_state = DPS_OP_ENABLED; // [RL7]
      DPS_OP_ENABLED:
        if (cmd_dis_voltage) next_state = DPS_ON_DISABLED; // [RL5]
        else if (cmd_qstop) next_state = DPS_QSTOP; // [RL6]
        else if (cmd_shutdown) next_state = DPS_READY; // [RL3]
        else if (cmd_switch_on) next_state = DPS_SWITCHED_ON; // [RL4]
      DPS_QSTOP:
        if (cmd_dis_voltage) next_state = DPS_ON_DISABLED; // [RL5]
        else if (cmd_enable && rise_qstop_n) next_state = DPS_OP_ENABLED; // [RL8]
      DPS_FAULT_REACT:
        if (fault_reaction_done) next_state = DPS_FAULT;
      DPS_FAULT:
        if (rise_fault_rst) next_state = DPS_ON_DISABLED; // [RL8] [RL12]
      default: next_state = DPS_NOT_READY;
    endcase
    // the self-test phase has no drive to react with, so faults are ignored until it ends
    if (fault_event && drive_state != DPS_NOT_READY && drive_state != DPS_FAULT_REACT
        && drive_state != DPS_FAULT)
      next_state = DPS_FAULT_REACT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // dictionary access: only the command and mode request objects are writable
  always_comb
  begin
    next_command = command_word;
    next_mode_req = mode_req;
    next_rsp = '0;
    if (obj_req.wr)
    begin
      next_rsp.valid = 1'b1;
      if (obj_req.index == DPS_IDX_COMMAND) next_command = obj_req.wdata; // [RL10]
      else if (obj_req.index == DPS_IDX_MODE_REQ) next_mode_req = obj_req.wdata[7:0]; // [RL11]
      else next_rsp.err = 1'b1; // status and active mode are read only
    end
    else if (obj_req.rd)
    begin
      next_rsp.valid = 1'b1;
      case (obj_req.index)
        DPS_IDX_COMMAND: next_rsp.rdata = command_word;
        DPS_IDX_STATE: next_rsp.rdata = drive_state_word; // [RL10]
        DPS_IDX_MODE_REQ: next_rsp.rdata = {8'h00, mode_req};
        DPS_IDX_MODE_ACT: next_rsp.rdata = {8'h00, active_mode}; // [RL11]
        default: next_rsp.err = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; status word is re-encoded from the next state so it never lags
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_state <= DPS_NOT_READY;
      drive_state_word <= 16'h0000;
      command_word <= DPS_COMMAND_RST;
      prev_command <= DPS_COMMAND_RST;
      mode_req <= DPS_MODE_RST;
      active_mode <= DPS_MODE_RST;
      obj_rsp <= '0;
    end
    else
    begin
      drive_state <= next_state;
      drive_state_word <= state_code(next_state); // [RL1] [RL2] [RL10]
      command_word <= next_command;
      prev_command <= command_word;
      mode_req <= next_mode_req;
      active_mode <= mode_req; // mode switch is accepted in every power state [RL11]
      obj_rsp <= next_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // encodings are checked on the registered state, which moves on the same edge as the word
  chk_status_disabled: assert property (drive_state == DPS_ON_DISABLED // [RL1]
    |-> drive_state_word[6] && drive_state_word[3:0] == 4'h0)
    else $error("switch on disabled not encoded");
  chk_status_ready: assert property (drive_state == DPS_READY // [RL1]
    |-> drive_state_word[6:5] == 2'b01 && drive_state_word[3:0] == 4'h1)
    else $error("ready to switch on not encoded");
  chk_status_enabled: assert property (drive_state == DPS_OP_ENABLED // [RL2]
    |-> drive_state_word[6:5] == 2'b01 && drive_state_word[3:0] == 4'h7)
    else $error("operation enabled not encoded");
  chk_status_qstop: assert property (drive_state == DPS_QSTOP // [RL2]
    |-> drive_state_word[6:5] == 2'b00 && drive_state_word[3:0] == 4'h7)
    else $error("quick stop not encoded");
  chk_status_fault: assert property (drive_state == DPS_FAULT // [RL2]
    |-> !drive_state_word[6] && drive_state_word[3:0] == 4'h8)
    else $error("fault not encoded");

  // transitions; antecedents exclude a core fault wherever it would override the command
  chk_shutdown_ready: assert property (drive_state == DPS_ON_DISABLED && cmd_shutdown && !fault_event // [RL3]
    |=> drive_state == DPS_READY)
    else $error("shutdown did not reach ready");
  chk_switch_on: assert property (drive_state == DPS_READY && command_word[7:0] == 8'h07 && !fault_event // [RL4]
    |=> drive_state == DPS_SWITCHED_ON)
    else $error("switch on not taken");
  chk_dis_voltage: assert property (cmd_dis_voltage && !fault_event // [RL5]
    && drive_state inside {DPS_READY, DPS_SWITCHED_ON, DPS_OP_ENABLED, DPS_QSTOP}
    |=> drive_state == DPS_ON_DISABLED)
    else $error("disable voltage ignored");
  chk_quick_stop: assert property (drive_state == DPS_OP_ENABLED && cmd_qstop && !fault_event // [RL6]
    |=> drive_state == DPS_QSTOP)
    else $error("quick stop ignored");
  chk_enable_op: assert property (drive_state == DPS_SWITCHED_ON && command_word[7:0] == 8'h0f // [RL7]
    && !fault_event |=> drive_state == DPS_OP_ENABLED)
    else $error("enable operation ignored");
  chk_fault_level: assert property (drive_state == DPS_FAULT && $past(command_word[7]) // [RL8]
    && command_word[7] |=> drive_state == DPS_FAULT)
    else $error("held fault reset acted again");
  // a quick stop bit that was already high must not bring the drive back
  chk_qstop_level: assert property (drive_state == DPS_QSTOP // [RL8]
    && $past(command_word[2]) && command_word[2] |=> drive_state != DPS_OP_ENABLED)
    else $error("held quick stop bit returned to operation");
  chk_qstop_return: assert property (drive_state == DPS_QSTOP && cmd_enable && !fault_event // [RL8]
    && $rose(command_word[2]) |=> drive_state == DPS_OP_ENABLED)
    else $error("quick stop return edge ignored");
  chk_fault_reset: assert property (drive_state == DPS_FAULT && $rose(command_word[7]) // [RL12]
    |=> drive_state == DPS_ON_DISABLED)
    else $error("fault reset edge ignored");
  chk_selftest: assert property (drive_state == DPS_NOT_READY && selftest_ok && !fault_event // [RL9]
    |=> drive_state == DPS_ON_DISABLED)
    else $error("self-test pass not followed");
  chk_notready_hold: assert property (drive_state == DPS_NOT_READY && !selftest_ok // [RL9]
    |=> drive_state == DPS_NOT_READY)
    else $error("left not ready before self-test");
  chk_status_ro: assert property (obj_req.wr && obj_req.index == DPS_IDX_STATE // [RL10]
    |=> $stable(command_word) && obj_rsp.err)
    else $error("status object accepted a write");
  chk_read_answer: assert property (obj_req.rd && !obj_req.wr // [RL10]
    |=> obj_rsp.valid)
    else $error("read got no answer");
  chk_mode_follow: assert property (obj_req.wr && obj_req.index == DPS_IDX_MODE_REQ && !$past(obj_req.wr) // [RL11]
    |-> ##2 active_mode == $past(obj_req.wdata[7:0], 2))
    else $error("active mode did not follow request");
  chk_unmatched_hold: assert property (drive_state == DPS_SWITCHED_ON && command_word[7:0] == 8'h86 // [RL13]
    && !fault_event |=> $stable(drive_state))
    else $error("unmatched command moved state");

  // main paths through the state graph
  cov_enable_path: cover property (drive_state == DPS_SWITCHED_ON ##1 drive_state == DPS_OP_ENABLED);
  cov_qstop_entry: cover property (drive_state == DPS_OP_ENABLED ##1 drive_state == DPS_QSTOP);
  cov_qstop_return: cover property (drive_state == DPS_QSTOP ##1 drive_state == DPS_OP_ENABLED);
  cov_fault_entry: cover property (drive_state == DPS_FAULT_REACT ##1 drive_state == DPS_FAULT);
  cov_fault_clear: cover property (drive_state == DPS_FAULT ##1 drive_state == DPS_ON_DISABLED);

endmodule

// ===== dps_master_model.sv
`timescale 1ns/1ps
module dps_master_model
  import dps_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // object port
  output dps_obj_req_t obj_req,
  input wire dps_obj_rsp_t obj_rsp
);
  initial obj_req = '0;
  // one strobe cycle, answer sampled 1 ns after the taking edge
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
    output dps_obj_rsp_t rsp);
    @(posedge ref_clk);
    #1;
    obj_req = '{wr: wr, rd: !wr, index: idx, wdata: wd};
    @(posedge ref_clk);
    #1;
    // released lines carry inverted leftovers so stale values never look valid
    obj_req = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
    rsp = obj_rsp;
  endtask
endmodule

// ===== dps_power_fsm_tb.sv
`timescale 1ns/1ps
module dps_power_fsm_tb
  import dps_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b1;
  logic selftest_ok = 1'b0;
  logic fault_event = 1'b0;
  logic fault_reaction_done = 1'b0;
  dps_obj_req_t obj_req;
  dps_obj_rsp_t obj_rsp;
  dps_state_t drive_state;
  logic [15:0] drive_state_word;
  logic [7:0] active_mode;
  int fail_count = 0;
  int n_compared = 0;

  dps_power_fsm dps_power_fsm_i (.ref_clk(ref_clk), .rstn(rstn), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .selftest_ok(selftest_ok), .fault_event(fault_event), .fault_reaction_done(fault_reaction_done),
    .drive_state(drive_state), .drive_state_word(drive_state_word), .active_mode(active_mode));
  dps_master_model dps_master_model_i (.ref_clk(ref_clk), .obj_req(obj_req), .obj_rsp(obj_rsp));

  // 10 MHz clock
  initial forever #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // bit 5 is only meaningful in the five middle states
  task automatic see(input dps_state_t s);
    logic [15:0] m;
    m = (s inside {DPS_NOT_READY, DPS_FAULT_REACT, DPS_FAULT}) ? 16'h004f : 16'h006f;
    check({13'h0000, drive_state}, {13'h0000, s}, "state");
    check(drive_state_word & m, 16'h0000 | {s == DPS_ON_DISABLED, s inside {DPS_READY, DPS_SWITCHED_ON,
      DPS_OP_ENABLED}, 1'b0, s inside {DPS_FAULT_REACT, DPS_FAULT}, s inside {DPS_OP_ENABLED, DPS_QSTOP,
      DPS_FAULT_REACT}, s inside {DPS_SWITCHED_ON, DPS_OP_ENABLED, DPS_QSTOP, DPS_FAULT_REACT},
      s inside {DPS_READY, DPS_SWITCHED_ON, DPS_OP_ENABLED, DPS_QSTOP, DPS_FAULT_REACT}}, "word");
  endtask
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] wd, input logic er,
    input logic [15:0] rd);
    dps_obj_rsp_t r;
    dps_master_model_i.access(wr, idx, wd, r);
    check({14'h0000, r.valid, r.err}, {15'h0001, er}, "answer");
    if (!wr)
      check(r.rdata, rd, "rdata");
  endtask
  task automatic cmd(input logic [15:0] wd, input dps_state_t s);
    acc(1'b1, DPS_IDX_COMMAND, wd, 1'b0, 16'h0000);
    @(posedge ref_clk);
    #1;
    see(s);
  endtask
  task automatic pulse(input logic done, input dps_state_t s);
    if (done)
      fault_reaction_done = 1'b1;
    else
      fault_event = 1'b1;
    @(posedge ref_clk);
    #1;
    fault_reaction_done = 1'b0;
    fault_event = 1'b0;
    see(s);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    // the drop comes after time zero so the asynchronous reset sees a real falling edge
    #1;
    rstn = 1'b0;
    #1;
    see(DPS_NOT_READY);
    repeat (5) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    see(DPS_NOT_READY);
    selftest_ok = 1'b1;
    @(posedge ref_clk);
    #1;
    see(DPS_ON_DISABLED);
  endtask
  // full walk, including ignored patterns and every shutdown entry
  task automatic t_walk();
    cmd(16'h000f, DPS_ON_DISABLED);
    cmd(16'h0006, DPS_READY);
    cmd(16'h000f, DPS_READY);
    cmd(16'h0007, DPS_SWITCHED_ON);
    cmd(16'h0086, DPS_SWITCHED_ON);
    cmd(16'h0006, DPS_READY);
    cmd(16'h0007, DPS_SWITCHED_ON);
    cmd(16'h000f, DPS_OP_ENABLED);
    cmd(16'h0007, DPS_SWITCHED_ON);
    cmd(16'h000f, DPS_OP_ENABLED);
    cmd(16'h000b, DPS_QSTOP);
    // raise the quick stop bit while blocked, then hold it: a steady level must not return
    cmd(16'h008f, DPS_QSTOP);
    cmd(16'h000f, DPS_QSTOP);
    cmd(16'h000b, DPS_QSTOP);
    cmd(16'h000f, DPS_OP_ENABLED);
    cmd(16'h000e, DPS_READY);
    cmd(16'h0005, DPS_ON_DISABLED);
  endtask
  // a held reset level must not clear the fault, only a fresh edge does
  task automatic t_fault();
    cmd(16'h0080, DPS_ON_DISABLED);
    pulse(1'b0, DPS_FAULT_REACT);
    pulse(1'b1, DPS_FAULT);
    acc(1'b1, DPS_IDX_MODE_REQ, 16'hff03, 1'b0, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    see(DPS_FAULT);
    check({8'h00, active_mode}, 16'h0003, "mode");
    cmd(16'h0000, DPS_FAULT);
    cmd(16'h0080, DPS_ON_DISABLED);
  endtask
  task automatic t_objects();
    acc(1'b0, DPS_IDX_COMMAND, 16'h0000, 1'b0, 16'h0080);
    acc(1'b0, DPS_IDX_MODE_REQ, 16'h0000, 1'b0, 16'h0003);
    acc(1'b1, DPS_IDX_MODE_ACT, 16'h0055, 1'b1, 16'h0000);
    acc(1'b0, DPS_IDX_MODE_ACT, 16'h0000, 1'b0, 16'h0003);
    acc(1'b0, DPS_IDX_STATE, 16'h0000, 1'b0, 16'h0040);
    acc(1'b1, DPS_IDX_STATE, 16'h0006, 1'b1, 16'h0000);
    acc(1'b0, 16'h1234, 16'h0000, 1'b1, 16'h0000);
    see(DPS_ON_DISABLED);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bound on the whole run
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    t_power_up();
    t_walk();
    t_fault();
    t_objects();
    give_verdict();
  end
endmodule
